// *** hw/led_pulse_and_pwm_generator.sv ***
// top: register slave on avalon-mm, two led pulse generators and one pwm
//
// Overview of operation
// - second led double mode: on, off, on for on time each, then dark.
// - second led single mode: one on pulse per period, then dark.
// - first led double mode: on, off, on for on time each, then dark.
// - first led single mode: one on pulse per period, then dark.
// - second led width code 0..3 gives 62.5, 125, 250, 500 ms.
// - first led width code in bits 1:0 gives 62.5 to 500 ms.
// - pwm rate code 0..3 gives 500, 250, 125, 62.5 Hz.
// - pwm high fraction is code over 256, never fully high.
// - scratch register stores and returns any byte, resets to zero.
// - revision register cleared only by full reset, not general reset.
// - revision bit 7 is a writable boot read enable, default zero.
// - revision bits 3:0 are a fixed read-only code, writes ignored.
// - led period code 0 keeps led dark, others give 0.125 s to 8 s.
`timescale 1ns/10ps
module led_pulse_and_pwm_generator #(
   parameter int         LED_TICK_CYCLES  = ledpwm_pkg::LED_TICK_CYCLES,
   parameter int         PWM_BASE_CYCLES  = ledpwm_pkg::PWM_BASE_CYCLES,
   parameter logic [3:0] SILICON_REVISION = 4'hA  // arbitrary value
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          general_rst,
   input  wire logic [ledpwm_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [ledpwm_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [ledpwm_pkg::DATA_W-1:0] avs_readdata,
   output logic                               avs_waitrequest,
   output logic                               first_led_out,
   output logic                               second_led_out,
   output logic                               pwm_out,
   output logic                               boot_mode_read_enable
);

   // bus handshake: one cycle to look, one cycle to answer
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

   typedef struct packed {
      bus_state_t  bus;
      logic        waitreq;
      logic [7:0]  rdata;
      // software registers
      logic [7:0]  led_interval;
      logic [7:0]  led_shape;
      logic [7:0]  pwm_rate;
      logic [7:0]  pwm_frac;
      logic [7:0]  scratch;
      logic        boot_read;
      // shared 62.5 ms time base
      logic [31:0] tick_cnt;
      logic        tick;
      // pwm engine
      logic [31:0] pwm_cnt;
      logic [31:0] pwm_period;
      logic [31:0] pwm_high;
      logic        pwm;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;

   logic [7:0] reg_index;
   logic       first_led;
   logic       second_led;

   // word index of the access; the two low address bits are dropped, only byte lane 0 is used and byteenable[0] gates writes
   assign reg_index = avs_address[ledpwm_pkg::ADDR_W-1:2];

   // pwm period in clocks: base period doubled once per rate step
   function automatic logic [31:0] pwm_period_of(input logic [1:0] code);
      pwm_period_of = 32'(PWM_BASE_CYCLES) << code;
   endfunction

   // high time in clocks: period scaled by code/256, rounded down
   function automatic logic [31:0] pwm_high_of(input logic [31:0] period,
                                               input logic [7:0]  frac);
      logic [39:0] prod;
      prod        = {8'h00, period} * {32'h00000000, frac};
      pwm_high_of = prod[ledpwm_pkg::PWM_STEPS_LOG2 +: 32];
   endfunction

   // register read view; reserved bits and unmapped words read zero
   function automatic logic [7:0] read_view(input logic [7:0] idx,
                                            input top_state_t s);
      case (idx)
         ledpwm_pkg::IDX_LED_INTERVAL: begin
            read_view = s.led_interval;
         end
         ledpwm_pkg::IDX_LED_SHAPE: begin
            read_view = s.led_shape;
         end
         ledpwm_pkg::IDX_PWM_RATE: begin
            read_view = s.pwm_rate;
         end
         ledpwm_pkg::IDX_PWM_FRAC: begin
            read_view = s.pwm_frac;
         end
         ledpwm_pkg::IDX_SCRATCH: begin
            read_view = s.scratch;
         end
         ledpwm_pkg::IDX_REVISION: begin
            read_view = {s.boot_read, 3'h0, SILICON_REVISION};
         end
         default: begin
            read_view = 8'h00;
         end
      endcase
   endfunction

   // next state of bus slave, registers, time base and pwm
   always_comb begin
      next_st = st;

      // avalon slave: waitrequest drops one cycle after the request is seen
      case (st.bus)
         BUS_IDLE: begin
            next_st.waitreq = 1'b1;
            if (avs_read || avs_write) begin
               next_st.bus     = BUS_ACK;
               next_st.waitreq = 1'b0;
               next_st.rdata   = read_view(reg_index, st);
            end
         end
         BUS_ACK: begin
            // the write lands on the edge that sees waitrequest low
            next_st.bus     = BUS_IDLE;
            next_st.waitreq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
               case (reg_index)
                  ledpwm_pkg::IDX_LED_INTERVAL: begin
                     next_st.led_interval = avs_writedata[7:0] &
                                            ledpwm_pkg::MASK_LED_INTERVAL;
                  end
                  ledpwm_pkg::IDX_LED_SHAPE: begin
                     next_st.led_shape = avs_writedata[7:0] &
                                         ledpwm_pkg::MASK_LED_SHAPE;
                  end
                  ledpwm_pkg::IDX_PWM_RATE: begin
                     next_st.pwm_rate = avs_writedata[7:0] &
                                        ledpwm_pkg::MASK_PWM_RATE;
                  end
                  ledpwm_pkg::IDX_PWM_FRAC: begin
                     next_st.pwm_frac = avs_writedata[7:0] &
                                        ledpwm_pkg::MASK_FULL;
                  end
                  ledpwm_pkg::IDX_SCRATCH: begin
                     next_st.scratch = avs_writedata[7:0];
                  end
                  ledpwm_pkg::IDX_REVISION: begin
                     // only the enable bit takes a write; the code is fixed
                     next_st.boot_read =
                        avs_writedata[ledpwm_pkg::BOOT_READ_BIT];
                  end
                  default: begin
                     next_st.bus = BUS_IDLE;  // unmapped: write dropped
                  end
               endcase
            end
         end
         default: begin
            next_st.bus     = BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase

      // one-cycle tick every 62.5 ms drives both led generators
      next_st.tick = 1'b0;
      if (st.tick_cnt + 32'h00000001 >= 32'(LED_TICK_CYCLES)) begin
         next_st.tick_cnt = 32'h00000000;
         next_st.tick     = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 32'h00000001;
      end

      // pwm: rate and fraction are latched at the period end, so a write
      // mid-period neither shortens nor stretches the current pulse
      if (st.pwm_cnt + 32'h00000001 >= st.pwm_period) begin
         next_st.pwm_cnt    = 32'h00000000;
         next_st.pwm_period = pwm_period_of(st.pwm_rate[1:0]);
         next_st.pwm_high   = pwm_high_of(next_st.pwm_period,
                                          st.pwm_frac);
      end else begin
         next_st.pwm_cnt = st.pwm_cnt + 32'h00000001;
      end
      // high fraction is at most 255/256, so the output always drops once
      next_st.pwm = next_st.pwm_cnt < next_st.pwm_high;

      // general reset clears led and pwm control but leaves the scratch and
      // revision registers, which belong to the full reset only
      if (general_rst) begin
         next_st.led_interval = ledpwm_pkg::REG_RESET;
         next_st.led_shape    = ledpwm_pkg::REG_RESET;
         next_st.pwm_rate     = ledpwm_pkg::REG_RESET;
         next_st.pwm_frac     = ledpwm_pkg::REG_RESET;
         next_st.pwm_cnt      = 32'h00000000;
         next_st.pwm_period   = 32'h00000000;
         next_st.pwm_high     = 32'h00000000;
         next_st.pwm          = 1'b0;
      end
   end

   // full reset: every field to its documented value
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st         <= '0;
         st.waitreq <= 1'b1;
         st.bus     <= BUS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // first led generator
   led_pulse_unit first_unit (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .general_rst   (general_rst),
      .tick          (st.tick),
      .interval_code (st.led_interval[ledpwm_pkg::FIRST_INTERVAL_LSB +: 3]),
      .width_code    (st.led_shape[ledpwm_pkg::FIRST_WIDTH_LSB +: 2]),
      .double_pulse  (st.led_shape[ledpwm_pkg::FIRST_DOUBLE_BIT]),
      .led_on        (first_led)
   );

   // second led generator
   led_pulse_unit second_unit (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .general_rst   (general_rst),
      .tick          (st.tick),
      .interval_code (st.led_interval[ledpwm_pkg::SECOND_INTERVAL_LSB +: 3]),
      .width_code    (st.led_shape[ledpwm_pkg::SECOND_WIDTH_LSB +: 2]),
      .double_pulse  (st.led_shape[ledpwm_pkg::SECOND_DOUBLE_BIT]),
      .led_on        (second_led)
   );

   // outputs, each straight from a flip-flop
   assign avs_readdata          = {24'h000000, st.rdata};
   assign avs_waitrequest       = st.waitreq;
   assign first_led_out         = first_led;
   assign second_led_out        = second_led;
   assign pwm_out               = st.pwm;
   assign boot_mode_read_enable = st.boot_read;

endmodule

// *** hw/ledpwm_pkg.sv ***
// package: register map, field layout and timing constants of the led/pwm block
package ledpwm_pkg;

   // clock and time base
   localparam int     CLK_PERIOD_NS   = 8;
   localparam longint LED_TICK_NS     = 62_500_000;  // shortest led on time, 62.5 ms
   localparam int     LED_TICK_CYCLES = int'(LED_TICK_NS / CLK_PERIOD_NS);
   localparam longint PWM_PERIOD_NS   = 2_000_000;   // 500 Hz base rate
   localparam int     PWM_BASE_CYCLES = int'(PWM_PERIOD_NS / CLK_PERIOD_NS);
   localparam int     PWM_STEPS_LOG2  = 8;           // duty in steps of 1/256

   // bus geometry: byte address, one register per aligned word
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_LED_INTERVAL = 8'h6C;
   localparam logic [7:0] IDX_LED_SHAPE    = 8'h6D;
   localparam logic [7:0] IDX_PWM_RATE     = 8'h6E;
   localparam logic [7:0] IDX_PWM_FRAC     = 8'h6F;
   localparam logic [7:0] IDX_SCRATCH      = 8'h70;
   localparam logic [7:0] IDX_REVISION     = 8'h80;

   // field positions
   localparam int FIRST_INTERVAL_LSB  = 0;
   localparam int SECOND_INTERVAL_LSB = 3;
   localparam int FIRST_WIDTH_LSB     = 0;
   localparam int SECOND_WIDTH_LSB    = 2;
   localparam int FIRST_DOUBLE_BIT    = 4;
   localparam int SECOND_DOUBLE_BIT   = 5;
   localparam int BOOT_READ_BIT       = 7;

   // writable bits of each register; the rest read as zero
   localparam logic [7:0] MASK_LED_INTERVAL = 8'h3F;
   localparam logic [7:0] MASK_LED_SHAPE    = 8'h3F;
   localparam logic [7:0] MASK_PWM_RATE     = 8'h03;
   localparam logic [7:0] MASK_FULL         = 8'hFF;

   // reset value of every register
   localparam logic [7:0] REG_RESET = 8'h00;

endpackage

// *** hw/led_pulse_unit.sv ***
// one led on/off pulse generator, counting in 62.5 ms ticks
`timescale 1ns/10ps
module led_pulse_unit (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       general_rst,
   input  wire logic       tick,
   input  wire logic [2:0] interval_code,
   input  wire logic [1:0] width_code,
   input  wire logic       double_pulse,
   output logic            led_on
);

   typedef struct packed {
      logic [7:0] pos;      // ticks into the current period
      logic [7:0] period;   // latched period in ticks, 0 = off
      logic [7:0] on_len;   // latched on time in ticks
      logic       dbl;      // latched double pulse select
      logic       led;
   } unit_state_t;

   unit_state_t st;
   unit_state_t next_st;

   // code 0 keeps the led dark; code n gives 2^n ticks (0.125 s .. 8 s)
   function automatic logic [7:0] period_ticks(input logic [2:0] code);
      period_ticks = (code == 3'h0) ? 8'h00 : 8'(8'h01 << code);
   endfunction

   // settings are taken only at a period boundary so a write never glitches
   always_comb begin
      next_st = st;
      if (tick) begin
         if (st.period == 8'h00 || st.pos >= st.period - 8'h01) begin
            next_st.pos    = 8'h00;
            next_st.period = period_ticks(interval_code);
            next_st.on_len = 8'(8'h01 << width_code);
            next_st.dbl    = double_pulse;
         end else begin
            next_st.pos = st.pos + 8'h01;
         end
      end
      // on, off, on for one on time each, then dark; a long on time is cut
      // short by the period end
      next_st.led = (next_st.period != 8'h00) &&
                    ((next_st.pos < next_st.on_len) ||
                     (next_st.dbl &&
                      next_st.pos >= 8'(next_st.on_len * 8'h02) &&
                      next_st.pos <  8'(next_st.on_len * 8'h03)));
      if (general_rst) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign led_on = st.led;

endmodule

// *** dv/led_pulse_and_pwm_generator_asserts.sv ***
// checker: bus answer timing, read fields and output relations of the led/pwm block
`timescale 1ns/10ps
module led_pulse_and_pwm_generator_asserts #(
   parameter int         LED_TICK_CYCLES  = 4,
   parameter int         PWM_BASE_CYCLES  = 256,
   parameter logic [3:0] SILICON_REVISION = 4'hA
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        general_rst,
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        first_led_out,
   input wire logic        second_led_out,
   input wire logic        pwm_out,
   input wire logic        boot_mode_read_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   int unsigned pwm_high_run;

   // length of the running pwm high stretch; a stuck-high output shows up here
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         pwm_high_run <= 0;
      else
         pwm_high_run <= pwm_out ? pwm_high_run + 1 : 0;
   end

   sequence answer_at(logic [7:0] idx);
      !avs_waitrequest && avs_address[9:2] == idx;
   endsequence

   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   answer_soon_a: assert property ($rose(avs_read) || $rose(avs_write) |-> ##[1:2] !avs_waitrequest)
      else $error("request not answered in time");
   upper_zero_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   rev_code_a: assert property (avs_read ##0 answer_at(8'h80) |-> avs_readdata[6:0] == {3'b000, SILICON_REVISION})
      else $error("revision code or reserved bits wrong");
   shape_rsv_a: assert property (avs_read ##0 answer_at(8'h6D) |-> avs_readdata[7:6] == 2'b00)
      else $error("shape reserved bits not zero");
   rate_rsv_a: assert property (avs_read ##0 answer_at(8'h6E) |-> avs_readdata[7:2] == 6'h00)
      else $error("rate reserved bits not zero");
   boot_set_a: assert property (avs_write && avs_byteenable[0] && avs_writedata[7] ##0 answer_at(8'h80) |-> ##[1:2] boot_mode_read_enable)
      else $error("boot read enable not set");
   boot_clear_a: assert property (avs_write && avs_byteenable[0] && !avs_writedata[7] ##0 answer_at(8'h80) |-> ##[1:2] !boot_mode_read_enable)
      else $error("boot read enable not cleared");
   boot_keep_a: assert property (general_rst && !avs_write && !$past(avs_write) && !$past(avs_write, 2) |=> $stable(boot_mode_read_enable))
      else $error("general reset touched boot read enable");
   gen_clear_a: assert property (general_rst |=> !first_led_out && !second_led_out && !pwm_out)
      else $error("general reset left an output active");
   never_full_a: assert property (pwm_high_run * 256 <= PWM_BASE_CYCLES * 8 * 255)
      else $error("pwm high longer than 255/256 of a period");
endmodule

bind led_pulse_and_pwm_generator led_pulse_and_pwm_generator_asserts #(
   .LED_TICK_CYCLES(LED_TICK_CYCLES),
   .PWM_BASE_CYCLES(PWM_BASE_CYCLES),
   .SILICON_REVISION(SILICON_REVISION)
) chk (
   .clk_sys(clk_sys), .rst(rst), .general_rst(general_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .first_led_out(first_led_out),
   .second_led_out(second_led_out), .pwm_out(pwm_out),
   .boot_mode_read_enable(boot_mode_read_enable)
);

// *** dv/test_led_pulse_and_pwm_generator.sv ***
// testbench: register access, reset domains, led patterns and pwm duty of the led/pwm block
`timescale 1ns/10ps
module test_led_pulse_and_pwm_generator;
   localparam int         TK  = 4;     // clocks per led tick, shortened to keep the run short
   localparam int         PB  = 256;   // fastest pwm period, one clock per duty step
   localparam logic [3:0] REV = 4'h5;  // arbitrary value
   logic        clk_sys        = 1'b0;
   logic        rst            = 1'b1;
   logic        general_rst    = 1'b0;
   logic [9:0]  avs_address    = 10'h000;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        first_led_out;
   logic        second_led_out;
   logic        pwm_out;
   logic        boot_mode_read_enable;
   logic [31:0] rd;
   int          n_fail    = 0;
   int          cmp_count = 0;
   int          hi [3];
   int          ri [3];

   led_pulse_and_pwm_generator #(.LED_TICK_CYCLES(TK), .PWM_BASE_CYCLES(PB),
      .SILICON_REVISION(REV)) uut (
      .clk_sys(clk_sys), .rst(rst), .general_rst(general_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .first_led_out(first_led_out),
      .second_led_out(second_led_out), .pwm_out(pwm_out),
      .boot_mode_read_enable(boot_mode_read_enable));

   // 125 MHz
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   task wrap_up;
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // one avalon transfer; held until waitrequest is sampled low, a lost answer ends the run
   task xfer(input logic is_wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
      int i;
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write <= is_wr;
      avs_read <= !is_wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 20) begin
         n_fail++;
         wrap_up();
      end
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, 4'h1);
   endtask

   task rdchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00, 4'h0);
      chk($sformatf("reg %0h", idx), {24'h000000, exp}, rd);
   endtask

   // high clocks and rising edges of the three outputs over n clocks
   task measure(input int n);
      logic [2:0] prev;
      logic [2:0] cur;
      hi = '{0, 0, 0};
      ri = '{0, 0, 0};
      prev = {pwm_out, second_led_out, first_led_out};
      repeat (n) begin
         @(negedge clk_sys);
         cur = {pwm_out, second_led_out, first_led_out};
         foreach (hi[j]) begin
            hi[j] += int'(cur[j]);
            ri[j] += int'(cur[j] & ~prev[j]);
         end
         prev = cur;
      end
   endtask

   task reset_values;
      logic [7:0] regs [5] = '{8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70};
      foreach (regs[k]) rdchk(regs[k], 8'h00);
      rdchk(8'h80, {4'h0, REV});
   endtask

   // write then read back, masked write, reserved and read-only bits, unmapped index
   task reg_access;
      wr(8'h70, 8'hA5);
      rdchk(8'h70, 8'hA5);
      xfer(1'b1, 8'h70, 8'h3C, 4'hE);
      rdchk(8'h70, 8'hA5);
      wr(8'h6D, 8'hFF);
      rdchk(8'h6D, 8'h3F);
      wr(8'h6E, 8'hFF);
      rdchk(8'h6E, 8'h03);
      wr(8'h6F, 8'hFF);
      rdchk(8'h6F, 8'hFF);
      wr(8'h80, 8'hFF);
      rdchk(8'h80, {4'h8, REV});
      chk("boot", 1'b1, boot_mode_read_enable);
      wr(8'h71, 8'hFF);
      rdchk(8'h71, 8'h00);
   endtask

   // general reset spares scratch and revision; the full reset domain keeps them
   task gen_reset;
      @(posedge clk_sys);
      general_rst <= 1'b1;
      @(posedge clk_sys);
      general_rst <= 1'b0;
      rdchk(8'h6D, 8'h00);
      rdchk(8'h6E, 8'h00);
      rdchk(8'h6F, 8'h00);
      rdchk(8'h70, 8'hA5);
      rdchk(8'h80, {4'h8, REV});
      wr(8'h80, 8'h00);
      rdchk(8'h80, {4'h0, REV});
      chk("boot", 1'b0, boot_mode_read_enable);
   endtask

   // every width code in single and double mode; settle two periods, then count one
   task led_shapes;
      int d;
      int w;
      wr(8'h6C, 8'h2D);
      for (d = 0; d < 2; d++) begin
         for (w = 0; w < 4; w++) begin
            wr(8'h6D, {2'b00, d[0], d[0], w[1:0], w[1:0]});
            measure(64 * TK);
            measure(32 * TK);
            chk("led1 on", ((1 + d) << w) * TK, hi[0]);
            chk("led1 pulses", 1 + d, ri[0]);
            chk("led2 on", ((1 + d) << w) * TK, hi[1]);
            chk("led2 pulses", 1 + d, ri[1]);
         end
      end
      wr(8'h6C, 8'h00);
      measure(64 * TK);
      measure(32 * TK);
      chk("led1 dark", 0, hi[0] + ri[0]);
      chk("led2 dark", 0, hi[1] + ri[1]);
      wr(8'h6D, 8'h00);
      wr(8'h6C, 8'h0A);
      measure(64 * TK);
      measure(32 * TK);
      chk("led1 pulses", 8, ri[0]);
      chk("led2 pulses", 16, ri[1]);
   endtask

   // each rate code; boundary duty values 0, 1 and 255 at rate code 0, 255 at rate code 3
   task pwm_duty;
      logic [9:0] cfg [7] = '{10'h000, 10'h001, 10'h080, 10'h0FF, 10'h140, 10'h2C8, 10'h3FF};
      foreach (cfg[k]) begin
         wr(8'h6E, {6'h00, cfg[k][9:8]});
         wr(8'h6F, cfg[k][7:0]);
         measure(4200);
         measure(PB << cfg[k][9:8]);
         chk("pwm high", cfg[k][7:0] << cfg[k][9:8], hi[2]);
         chk("pwm pulses", cfg[k][7:0] != 8'h00, ri[2]);
      end
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      reset_values();
      reg_access();
      gen_reset();
      led_shapes();
      pwm_duty();
      wrap_up();
   end
endmodule
